//--- hw/atrr_pkg.sv
package atrr_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] ADDR_CONV_RESULT = 8'h0d << 2;
	localparam logic [7:0] ADDR_TUNE_RESULT = 8'h0e << 2;
	localparam logic [7:0] ADDR_MANUAL_TRIM = 8'h3c;
	localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h40;
	localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h44;
	localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h48;

	// Field positions.
	localparam int TRIM_MSB      = 7;
	localparam int TRIM_LSB      = 4;
	localparam int TUNE_ERR_BIT  = 3;
	localparam int SRC_SEL_BIT   = 7;
	localparam int MAN_TRIM_MSB  = 6;
	localparam int MAN_TRIM_LSB  = 3;

	// Interrupt bit positions.
	localparam int IRQ_CONV_BIT  = 0;
	localparam int IRQ_TUNE_BIT  = 1;
	localparam int IRQ_WIDTH     = 2;

	// Reset values and AXI responses.
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Tuning sequence completion carrier.
	typedef struct packed {
		logic       done;
		logic [3:0] code;
		logic       fail;
	} atrr_tune_t;

	// Conversion completion carrier.
	typedef struct packed {
		logic       done;
		logic [7:0] value;
	} atrr_conv_t;

endpackage : atrr_pkg

//--- hw/atrr_regs.sv
`timescale 1ns/1ns
module atrr_regs #(
	parameter int ADDR_W = 8
) (
	input  wire logic                clk_in,
	input  wire logic                arst_n_in,
	input  wire logic                restore_in,
	input  wire atrr_pkg::atrr_conv_t conv_in,
	input  wire atrr_pkg::atrr_tune_t tune_in,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr_in,
	input  wire logic                s_axi_awvalid_in,
	output logic                     s_axi_awready_out,
	input  wire logic [31:0]         s_axi_wdata_in,
	input  wire logic [3:0]          s_axi_wstrb_in,
	input  wire logic                s_axi_wvalid_in,
	output logic                     s_axi_wready_out,
	output logic [1:0]               s_axi_bresp_out,
	output logic                     s_axi_bvalid_out,
	input  wire logic                s_axi_bready_in,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr_in,
	input  wire logic                s_axi_arvalid_in,
	output logic                     s_axi_arready_out,
	output logic [31:0]              s_axi_rdata_out,
	output logic [1:0]               s_axi_rresp_out,
	output logic                     s_axi_rvalid_out,
	input  wire logic                s_axi_rready_in,
	output logic [3:0]               tuning_pin_group_a_out,
	output logic [3:0]               tuning_pin_group_b_out,
	output logic                     irq_out
);

	// The register map uses byte addresses on the bus.
	//   0x34 converter result, read only, latest conversion in bits 7:0.
	//   0x38 calibration result, read only, trim code in 7:4, failure flag in 3.
	//   0x3c manual trim, read and write, source select in 7, code in 6:3.
	//   0x40 interrupt status, read only, bit 0 conversion, bit 1 tuning.
	//   0x44 interrupt enable, read and write, same layout as the status.
	//   0x48 interrupt clear, write only, a 1 clears the matching status bit.
	// Any other address answers with an error and reads as zero.
	// Restore-defaults leaves the interrupt registers alone, so software
	// still sees the completion events that came before it.

	// Elaboration check: the map needs eight address bits.
	if (ADDR_W < 8) begin : g_chk
		$error("ADDR_W must be at least 8");
	end

	// Elaboration check: interrupt bits must fit the low byte of a word.
	if (atrr_pkg::IRQ_WIDTH > 8) begin : g_chk_irq
		$error("IRQ_WIDTH must be at most 8");
	end

	logic       rst_meta_ff;
	logic       rst_sync_ff;
	logic [7:0] conv_result_ff;
	logic [7:0] tune_result_ff;
	logic [7:0] manual_trim_ff;
	logic [atrr_pkg::IRQ_WIDTH-1:0] irq_status_ff;
	logic [atrr_pkg::IRQ_WIDTH-1:0] irq_enable_ff;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic              aw_have_ff;
	logic [31:0]       w_data_ff;
	logic [3:0]        w_strb_ff;
	logic              w_have_ff;
	logic              wr_fire;
	logic [7:0]        wr_addr8;
	logic [7:0]        rd_addr8;
	localparam int IRQ_WIDTH_L = atrr_pkg::IRQ_WIDTH;
	logic [IRQ_WIDTH_L-1:0] irq_clear;
	logic [IRQ_WIDTH_L-1:0] irq_events;
	logic [3:0]        nxt_trim;
	logic              wr_manual;
	logic              wr_enable;
	logic              wr_clear;

	// True when a write goes to the given register with its low byte lane enabled.
	// The upper lanes carry nothing, so a write without lane 0 changes no state.
	function automatic logic wr_hit(
		input logic [7:0] addr,
		input logic [3:0] strb,
		input logic [7:0] target
	);
		wr_hit = (addr == target) && strb[0];
	endfunction : wr_hit

	// Places an 8-bit register in the low byte of a bus word, upper bits zero.
	function automatic logic [31:0] zext8(input logic [7:0] value);
		zext8 = {24'h0, value};
	endfunction : zext8

	// Reset release through two flip-flops.
	// Assertion stays asynchronous; only the release waits for two edges, so
	// every register leaves reset on the same clock edge.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// Write happens once both address and data have been taken.
	assign wr_fire  = aw_have_ff && w_have_ff && !s_axi_bvalid_out;
	assign wr_addr8 = aw_addr_ff[7:0];
	assign rd_addr8 = s_axi_araddr_in[7:0];

	// Register write strobes, one for each writable register.
	assign wr_manual = wr_fire && wr_hit(wr_addr8, w_strb_ff, atrr_pkg::ADDR_MANUAL_TRIM);
	assign wr_enable = wr_fire && wr_hit(wr_addr8, w_strb_ff, atrr_pkg::ADDR_IRQ_ENABLE);
	assign wr_clear  = wr_fire && wr_hit(wr_addr8, w_strb_ff, atrr_pkg::ADDR_IRQ_CLEAR);

	// Address and data capture, taken in either order.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			aw_have_ff        <= 1'b0;
			w_have_ff         <= 1'b0;
			aw_addr_ff        <= '0;
			w_data_ff         <= 32'h0;
			w_strb_ff         <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
		end else begin
			// No new address or data is taken while a write answer still waits.
			s_axi_awready_out <= !aw_have_ff && !s_axi_awready_out && !s_axi_bvalid_out;
			s_axi_wready_out  <= !w_have_ff && !s_axi_wready_out && !s_axi_bvalid_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end else if (wr_fire) begin
				aw_have_ff <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata_in;
				w_strb_ff <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end else if (wr_fire) begin
				w_have_ff <= 1'b0;
			end
		end
	end

	// Write response, error for an unmapped or read-only address.
	// A refused write still answers, so the master never waits forever.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= atrr_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			if (wr_addr8 == atrr_pkg::ADDR_MANUAL_TRIM || wr_addr8 == atrr_pkg::ADDR_IRQ_ENABLE ||
			    wr_addr8 == atrr_pkg::ADDR_IRQ_CLEAR) begin
				s_axi_bresp_out <= atrr_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp_out <= atrr_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bvalid_out && s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// Manual trim register keeps only select and code bits.
	// Bits 2:0 are dropped on write and therefore always read as zero.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			manual_trim_ff <= atrr_pkg::REG_RESET;
		end else if (restore_in) begin
			manual_trim_ff <= atrr_pkg::REG_RESET;
		end else if (wr_manual) begin
			manual_trim_ff <= {w_data_ff[atrr_pkg::SRC_SEL_BIT:atrr_pkg::MAN_TRIM_LSB], 3'h0};
		end
	end

	// Converter result capture.
	// Restore-defaults wins over a conversion finishing in the same cycle.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			conv_result_ff <= atrr_pkg::REG_RESET;
		end else if (restore_in) begin
			conv_result_ff <= atrr_pkg::REG_RESET;
		end else if (conv_in.done) begin
			conv_result_ff <= conv_in.value;
		end
	end

	// Calibration result capture at tuning completion.
	// The unused low bits are forced to zero here rather than at the read.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			tune_result_ff <= atrr_pkg::REG_RESET;
		end else if (restore_in) begin
			tune_result_ff <= atrr_pkg::REG_RESET;
		end else if (tune_in.done) begin
			tune_result_ff <= {tune_in.code, tune_in.fail, 3'h0};
		end
	end

	// Interrupt events and clears; a new event wins over a clear.
	assign irq_events = {tune_in.done, conv_in.done};
	assign irq_clear  = wr_clear ? w_data_ff[IRQ_WIDTH_L-1:0] : '0;

	// Sticky status bits; an event in the cycle of its clear keeps the bit set.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			irq_status_ff <= '0;
		end else begin
			irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_events;
		end
	end

	// Interrupt enable register, same layout as the status.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			irq_enable_ff <= '0;
		end else if (wr_enable) begin
			irq_enable_ff <= w_data_ff[IRQ_WIDTH_L-1:0];
		end
	end

	// Interrupt line registered from status and enable.
	// It follows the status one cycle late, which keeps the pin on a flip-flop.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_status_ff & irq_enable_ff);
		end
	end

	// Read channel, one cycle after the address is taken.
	// The address is decoded at the handshake edge, so the data shown is the
	// register value of that edge and stays put until the master takes it.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= atrr_pkg::RESP_OKAY;
		end else begin
			s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out && !s_axi_arvalid_in ?
			                     1'b1 : (!s_axi_rvalid_out && !s_axi_arready_out);
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out  <= 1'b1;
				s_axi_rresp_out   <= atrr_pkg::RESP_OKAY;
				case (rd_addr8)
					atrr_pkg::ADDR_CONV_RESULT: s_axi_rdata_out <= zext8(conv_result_ff);
					atrr_pkg::ADDR_TUNE_RESULT: s_axi_rdata_out <= zext8(tune_result_ff);
					atrr_pkg::ADDR_MANUAL_TRIM: s_axi_rdata_out <= zext8(manual_trim_ff);
					atrr_pkg::ADDR_IRQ_STATUS:  s_axi_rdata_out <= zext8(8'(irq_status_ff));
					atrr_pkg::ADDR_IRQ_ENABLE:  s_axi_rdata_out <= zext8(8'(irq_enable_ff));
					default: begin
						s_axi_rdata_out <= 32'h0;
						s_axi_rresp_out <= atrr_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// Trim source multiplex.
	// The select bit picks between the tuning result and the software code.
	always_comb begin
		if (manual_trim_ff[atrr_pkg::SRC_SEL_BIT]) begin
			nxt_trim = manual_trim_ff[atrr_pkg::MAN_TRIM_MSB:atrr_pkg::MAN_TRIM_LSB];
		end else begin
			nxt_trim = tune_result_ff[atrr_pkg::TRIM_MSB:atrr_pkg::TRIM_LSB];
		end
	end

	// Registered drive to both tuning pin groups.
	// Both groups carry the same code; registering them keeps the switch
	// drive free of glitches while the select bit and code change together.
	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			tuning_pin_group_a_out <= 4'h0;
			tuning_pin_group_b_out <= 4'h0;
		end else begin
			tuning_pin_group_a_out <= nxt_trim;
			tuning_pin_group_b_out <= nxt_trim;
		end
	end

endmodule : atrr_regs

//--- verif/atrr_regs_asserts.sv
`timescale 1ns/1ns
// Bus handshake and trim drive checks on the register slice's ports.
module atrr_regs_asserts (
	input wire logic                 clk_in,
	input wire logic                 arst_n_in,
	input wire logic                 restore_in,
	input wire atrr_pkg::atrr_tune_t tune_in,
	input wire logic                 s_axi_awvalid_in,
	input wire logic                 s_axi_awready_out,
	input wire logic                 s_axi_bvalid_out,
	input wire logic                 s_axi_bready_in,
	input wire logic [1:0]           s_axi_bresp_out,
	input wire logic                 s_axi_arvalid_in,
	input wire logic                 s_axi_arready_out,
	input wire logic                 s_axi_rvalid_out,
	input wire logic                 s_axi_rready_in,
	input wire logic [31:0]          s_axi_rdata_out,
	input wire logic [1:0]           s_axi_rresp_out,
	input wire logic [3:0]           tuning_pin_group_a_out,
	input wire logic [3:0]           tuning_pin_group_b_out
);
	// All checks share one clock and the asynchronous reset.
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	property p_grp; tuning_pin_group_a_out == tuning_pin_group_b_out; endproperty
	a_grp: assert property (p_grp) else $error("trim groups differ");
	property p_rst; (restore_in && !tune_in.done) [*2] |=> tuning_pin_group_a_out == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("trim not cleared");
	property p_bh; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
	a_bh: assert property (p_bh) else $error("write answer dropped");
	property p_rh; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
	a_rh: assert property (p_rh) else $error("read answer dropped");
	property p_ra; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
	a_ra: assert property (p_ra) else $error("read answer late");
	property p_ba; s_axi_awvalid_in && s_axi_awready_out |-> ##[1:4] s_axi_bvalid_out; endproperty
	a_ba: assert property (p_ba) else $error("write answer late");
	property p_nb; s_axi_bvalid_out |-> !s_axi_awready_out; endproperty
	a_nb: assert property (p_nb) else $error("address taken while pending");
	property p_er; s_axi_rvalid_out && s_axi_rresp_out == 2'h2 |-> s_axi_rdata_out == 32'h0; endproperty
	a_er: assert property (p_er) else $error("refused read carries data");
	cover property (tune_in.done);
	cover property (restore_in [*2]);
	cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2);
endmodule : atrr_regs_asserts

bind atrr_regs atrr_regs_asserts i_atrr_regs_asserts (.clk_in, .arst_n_in, .restore_in, .tune_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
	.s_axi_rdata_out, .s_axi_rresp_out, .tuning_pin_group_a_out, .tuning_pin_group_b_out);

//--- verif/atrr_regs_bench.sv
`timescale 1ns/1ns
// Drives bus and events, keeps a model of every register and compares.
module atrr_regs_bench;
	logic clk_in = 1'h0;
	logic arst_n_in = 1'h0;
	logic restore_in = 1'h0;
	atrr_pkg::atrr_conv_t conv_in = '0;
	atrr_pkg::atrr_tune_t tune_in = '0;
	logic [7:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
	logic [31:0] s_axi_wdata_in = '0;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
	logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, irq_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [31:0] s_axi_rdata_out, r;
	logic [3:0] tuning_pin_group_a_out, tuning_pin_group_b_out;
	logic [7:0] conv_m = '0, cal_m = '0, man_m = '0, st_m = '0, en_m = '0;
	int failures = 0, compares = 0, cyc = 0;

	atrr_regs i_atrr_regs (.clk_in, .arst_n_in, .restore_in, .conv_in, .tune_in,
		.s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
		.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
		.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
		.s_axi_rready_in, .tuning_pin_group_a_out, .tuning_pin_group_b_out, .irq_out);

	// Clock, and a ceiling on run length so a hung handshake still ends.
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			close_out();
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out

	// Write: address and data offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
		end while (s_axi_awvalid_in || s_axi_wvalid_in);
		do @(posedge clk_in); while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'h0;
		chk(32'(s_axi_bresp_out), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		do @(posedge clk_in); while (!s_axi_arready_out);
		s_axi_arvalid_in <= 1'h0;
		do @(posedge clk_in); while (!s_axi_rvalid_out);
		s_axi_rready_in <= 1'h0;
		chk(s_axi_rdata_out, e);
		chk(32'(s_axi_rresp_out), 32'(er));
	endtask : rd

	// One-cycle completion pulse from the converter or the tuning sequence.
	task automatic ev(input logic c, input logic [7:0] v);
		@(posedge clk_in);
		if (c) conv_in <= {1'h1, v};
		else tune_in <= {1'h1, v[3:0], v[4]};
		@(posedge clk_in);
		conv_in <= '0;
		tune_in <= '0;
		if (c) conv_m = v;
		else cal_m = {v[3:0], v[4], 3'h0};
		st_m[c ? 0 : 1] = 1'h1;
	endtask : ev

	// Reads every register and checks trim drive and interrupt against the model.
	task automatic rd_all();
		logic [3:0] e;
		rd(8'h34, 32'(conv_m), 2'h0);
		rd(8'h38, 32'(cal_m), 2'h0);
		rd(8'h3c, 32'(man_m), 2'h0);
		rd(8'h40, 32'(st_m), 2'h0);
		rd(8'h44, 32'(en_m), 2'h0);
		e = man_m[7] ? man_m[6:3] : cal_m[7:4];
		chk(32'(tuning_pin_group_a_out), 32'(e));
		chk(32'(tuning_pin_group_b_out), 32'(e));
		chk(32'(irq_out), 32'(|(st_m & en_m)));
	endtask : rd_all

	// Main sequence.
	initial begin
		int t;
		void'($urandom(32'h50df));
		repeat (4) @(posedge clk_in);
		arst_n_in <= 1'h1;
		repeat (4) @(posedge clk_in);
		rd_all();
		rd(8'h80, 32'h0, 2'h2);
		$display("test reset done");
		wr(8'h44, 32'h3, 2'h0);
		en_m = 8'h3;
		for (t = 0; t < 6; t++) begin
			r = $urandom;
			ev(1'h1, r[7:0]);
			ev(1'h0, r[15:8]);
			rd_all();
		end
		$display("test events done");
		wr(8'h48, 32'h3, 2'h0);
		st_m = 8'h0;
		wr(8'h44, 32'h1, 2'h0);
		en_m = 8'h1;
		ev(1'h0, 8'h1f);
		rd_all();
		$display("test irq done");
		for (t = 0; t < 6; t++) begin
			r = $urandom;
			r[7] = t[0];
			wr(8'h3c, r, 2'h0);
			man_m = r[7:0] & 8'hf8;
			rd_all();
		end
		wr(8'h34, 32'h5a, 2'h2);
		wr(8'h38, 32'h5a, 2'h2);
		wr(8'h80, 32'h5a, 2'h2);
		rd_all();
		$display("test manual done");
		restore_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		restore_in <= 1'h0;
		conv_m = 8'h0;
		cal_m = 8'h0;
		man_m = 8'h0;
		rd_all();
		$display("test restore done");
		close_out();
	end
endmodule : atrr_regs_bench
